// file: core/tld_hyst_cmp.sv
// Threshold comparator with hysteresis for one level tier.
// Assumes the sample strobe is one cycle long, once per burst.
`timescale 1ns/100ps
module tld_hyst_cmp (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic sample_i,
  input wire logic [tld_pkg::COUNT_W-1:0] count_i,
  input wire logic [tld_pkg::COUNT_W-1:0] threshold_i,
  output logic detect_o
);
  import tld_pkg::*;

  // ****************************************************************
  // Decision
  // ****************************************************************
  logic [COUNT_W:0] release_level; // One bit wider, never wraps
  logic trip_hit; // Count at or below trip point
  logic release_hit; // Count clear of the band

  assign release_level = {1'b0, threshold_i} + {1'b0, HYST_COUNTS};
  assign trip_hit = (count_i <= threshold_i);
  assign release_hit = ({1'b0, count_i} > release_level);

  // Detect flag, only moved by a burst result
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      detect_o <= 1'b0;
    end else if (sample_i) begin
      if (!detect_o && trip_hit) begin
        detect_o <= 1'b1;
      end else if (detect_o && release_hit) begin
        detect_o <= 1'b0;
      end
    end
  end

endmodule : tld_hyst_cmp

// file: core/tld_level_detect.sv
// Top of the two-tier level decision logic: burst sequencer, two
// comparator and filter channels, output pin drive and a register port.
// Assumes a front end that starts a burst on request and returns the
// per-burst signal count with a one-cycle valid strobe. Straps are
// synchronous levels.
`timescale 1ns/100ps

// ****************************************************************
// Module
// ****************************************************************
module tld_level_detect #(
  parameter int HEALTH_CYC = tld_pkg::HEALTH_CYCLES, // Health float length
  parameter int PERIOD_CYC = tld_pkg::BURST_PERIOD_CYCLES, // Burst spacing
  parameter int TIMEOUT_CYC = tld_pkg::BURST_TIMEOUT_CYCLES // Burst watchdog
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic filter_enable_strap_i,
  input wire logic output_polarity_strap_i,
  output logic burst_start_o,
  input wire logic [tld_pkg::COUNT_W-1:0] count_i,
  input wire logic count_valid_i,
  output logic lower_tier_level_output_o,
  output logic lower_tier_level_output_oe_b_o,
  output logic upper_tier_level_output_o,
  output logic upper_tier_level_output_oe_b_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o
);
  import tld_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tld_state_e state; // Sequencer state
  tld_state_e next_state; // Sequencer next state
  logic [31:0] timer; // Shared phase timer
  logic [31:0] next_timer; // Timer next value
  logic period_done; // Idle gap over
  logic health_done; // Float window over
  logic burst_timeout; // Front end too slow
  logic count_taken; // Count accepted this cycle
  logic step; // Filter step, one cycle after the compare
  logic [COUNT_W-1:0] thresholds [2]; // Fixed trip points per tier
  logic [1:0] detect; // Comparator results
  logic [1:0] active; // Filtered output states
  logic [1:0] active_q; // Last cycle, for change events
  logic [FILTER_ENABLE_STRAP_W-1:0] filter_enable_strap_count [2]; // Integration counters
  logic [1:0] pin_level; // Driven pin levels
  logic [3:0] status; // Sticky events
  logic [3:0] next_status; // Status next value
  logic [3:0] events; // Events this cycle
  logic [3:0] clear_bits; // Write-one-to-clear bits
  logic [3:0] mask; // Interrupt enables
  logic sel_status; // Address decodes
  logic sel_mask;
  logic sel_state;
  logic [31:0] state_word; // Live state for readback
  logic [31:0] next_rdata; // Read mux output

  // ****************************************************************
  // Burst sequencer
  // ****************************************************************
  // Timer limits come from top parameters so simulation can shorten them
  assign period_done = (timer >= 32'(PERIOD_CYC - 1));
  assign health_done = (timer >= 32'(HEALTH_CYC - 1));
  assign burst_timeout = (timer >= 32'(TIMEOUT_CYC - 1));
  assign count_taken = state[2] && count_valid_i;

  // Next state and timer
  always_comb begin
    next_state = state;
    next_timer = timer + 32'h0000_0001;
    unique case (state)
      TLD_IDLE: begin
        // Quiet gap between bursts
        if (period_done) begin
          next_state = TLD_HEALTH;
          next_timer = 32'h0000_0000;
        end
      end
      TLD_HEALTH: begin
        // Outputs float, then the burst is requested
        if (health_done) begin
          next_state = TLD_BURST;
          next_timer = 32'h0000_0000;
        end
      end
      TLD_BURST: begin
        // Wait for the count or give up
        if (count_valid_i || burst_timeout) begin
          next_state = TLD_IDLE;
          next_timer = 32'h0000_0000;
        end
      end
      default: begin
        // Corrupt one-hot code, recover through idle
        next_state = TLD_IDLE;
        next_timer = 32'h0000_0000;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state <= TLD_IDLE;
      timer <= 32'h0000_0000;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // Burst request on entry to the burst phase
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      burst_start_o <= 1'b0;
    end else begin
      burst_start_o <= state[1] && health_done;
    end
  end

  // Filter step trails the comparator update by one cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      step <= 1'b0;
    end else begin
      step <= count_taken;
    end
  end

  // ****************************************************************
  // Tier channels
  // ****************************************************************
  // fixed trip points
  assign thresholds[0] = LOWER_TRIP_THRESHOLD;
  assign thresholds[1] = UPPER_TRIP_THRESHOLD;

  for (genvar ch = 0; ch < 2; ch++) begin : g_tier
    // Both comparators see the same count, only when a burst count is taken
    tld_hyst_cmp u_cmp (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .sample_i(count_taken),
      .count_i(count_i),
      .threshold_i(thresholds[ch]),
      .detect_o(detect[ch])
    );

    tld_slosh_filter u_filter_enable_strap (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .step_i(step),
      .detect_i(detect[ch]),
      .enable_i(filter_enable_strap_i),
      .active_o(active[ch]),
      .count_o(filter_enable_strap_count[ch])
    );

    assign pin_level[ch] = active[ch] ? output_polarity_strap_i : !output_polarity_strap_i;
  end

  // ****************************************************************
  // Output pins
  // ****************************************************************
  // each pin carries its own tier
  // level held while active, no timer
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      lower_tier_level_output_o <= 1'b0;
      upper_tier_level_output_o <= 1'b0;
    end else begin
      lower_tier_level_output_o <= pin_level[0];
      upper_tier_level_output_o <= pin_level[1];
    end
  end

  // both pins float during the health window
  assign lower_tier_level_output_oe_b_o = state[1];
  assign upper_tier_level_output_oe_b_o = state[1];

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  assign sel_status = (reg_addr_i == REG_STATUS);
  assign sel_mask = (reg_addr_i == REG_MASK);
  assign sel_state = (reg_addr_i == REG_STATE);

  // Live state word: detects, outputs, strap levels, counters
  assign state_word = {8'h00, filter_enable_strap_count[1], filter_enable_strap_count[0],
                       2'b00, output_polarity_strap_i, filter_enable_strap_i,
                       active, detect};

  // Read mux, unmapped addresses read zero
  assign next_rdata = sel_status ? {28'h000_0000, status} :
                      sel_mask ? {28'h000_0000, mask} :
                      sel_state ? state_word : 32'h0000_0000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // Mask register, low bits only
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mask <= MASK_RESET;
    end else if (reg_wr_i && sel_mask) begin
      mask <= reg_wdata_i[3:0];
    end
  end

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  // Previous output state for change detection
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      active_q <= 2'b00;
    end else begin
      active_q <= active;
    end
  end

  assign events[EV_LOWER_CHG] = active[0] ^ active_q[0];
  assign events[EV_UPPER_CHG] = active[1] ^ active_q[1];
  assign events[EV_BURST_DONE] = count_taken;
  assign events[EV_TIMEOUT] = state[2] && !count_valid_i && burst_timeout;
  assign clear_bits = (reg_wr_i && sel_status) ? reg_wdata_i[3:0] : 4'h0;

  // A new event beats a clear in the same cycle
  assign next_status = (status & ~clear_bits) | events;

  // Sticky status
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      status <= STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // Level interrupt, high while any enabled event is pending
  assign irq_o = |(status & mask);

endmodule : tld_level_detect

// file: core/tld_slosh_filter.sv
// Detection integration filter for one level tier.
// Assumes one step strobe per burst, after the comparator has settled.
`timescale 1ns/100ps
module tld_slosh_filter (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic step_i,
  input wire logic detect_i,
  input wire logic enable_i,
  output logic active_o,
  output logic [tld_pkg::FILTER_ENABLE_STRAP_W-1:0] count_o
);
  import tld_pkg::*;

  // ****************************************************************
  // Integrator
  // ****************************************************************
  logic at_limit; // Counter full
  logic at_zero; // Counter empty

  assign at_limit = (count_o == FILTER_LIMIT);
  assign at_zero = (count_o == FILTER_ENABLE_STRAP_RESET);

  // Counter and output state
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      count_o <= FILTER_ENABLE_STRAP_RESET;
      active_o <= 1'b0;
    end else if (!enable_i) begin
      count_o <= active_o ? FILTER_LIMIT : FILTER_ENABLE_STRAP_RESET;
      if (step_i) begin
        active_o <= detect_i;
      end
    end else if (step_i) begin
      if (detect_i) begin
        if (!at_limit) begin
          count_o <= count_o + 8'h01;
        end
        if (count_o == FILTER_LIMIT - 8'h01 || at_limit) begin
          active_o <= 1'b1;
        end
      end else begin
        if (!at_zero) begin
          count_o <= count_o - 8'h01;
        end
        if (count_o == 8'h01 || at_zero) begin
          active_o <= 1'b0;
        end
      end
    end
  end

endmodule : tld_slosh_filter

// file: include/tld_pkg.sv
// Constants shared by the two-tier level decision logic.
// Assumes a 100 MHz system clock and a front end that reports one count per burst.
package tld_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_FREQ_HZ = 100_000_000; // System clock rate
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ; // 10 ns
  localparam int HEALTH_TIME_US = 350; // Outputs float before each burst
  localparam int HEALTH_CYCLES = (HEALTH_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COUNT_TIME_NS = 7000; // Average length of one burst count
  localparam int COUNT_CYCLES = (COUNT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_PERIOD_MS = 100; // Burst repetition period
  localparam int BURST_PERIOD_CYCLES = BURST_PERIOD_MS * (CLK_FREQ_HZ / 1000);
  localparam int FILTER_TIME_MS = 15_000; // Nominal settle time of the filter
  localparam int MAX_COUNT = 1023; // Largest count the front end reports
  localparam int BURST_TIMEOUT_CYCLES = (MAX_COUNT + 1) * COUNT_CYCLES;

  // ****************************************************************
  // Signal count thresholds
  // ****************************************************************
  localparam int COUNT_W = 10; // Width of the per-burst signal count
  localparam logic [9:0] LOWER_TRIP_THRESHOLD = 10'h0FA; // 250 counts
  localparam logic [9:0] UPPER_TRIP_THRESHOLD = 10'h096; // 150 counts
  localparam logic [9:0] HYST_COUNTS = 10'h003; // Hysteresis band

  // ****************************************************************
  // Integration filter
  // ****************************************************************
  localparam int FILTER_ENABLE_STRAP_W = 8; // Integration counter width
  localparam logic [7:0] FILTER_LIMIT = 8'(FILTER_TIME_MS / BURST_PERIOD_MS);
  localparam logic [7:0] FILTER_ENABLE_STRAP_RESET = 8'h00; // Counter after reset

  // ****************************************************************
  // Register port
  // ****************************************************************
  localparam logic [7:0] REG_STATUS = 8'h00; // Sticky events, write one to clear
  localparam logic [7:0] REG_MASK = 8'h04; // Interrupt enables
  localparam logic [7:0] REG_STATE = 8'h08; // Live decision state, read only
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam int EV_LOWER_CHG = 0; // Lower output changed
  localparam int EV_UPPER_CHG = 1; // Upper output changed
  localparam int EV_BURST_DONE = 2; // Burst count taken
  localparam int EV_TIMEOUT = 3; // No count before the timeout

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    TLD_IDLE = 3'b001,
    TLD_HEALTH = 3'b010,
    TLD_BURST = 3'b100
  } tld_state_e;

endpackage : tld_pkg

// file: tb/tld_front_end_model.sv
// Behavioural front end: answers each burst request with one count.
// Assumes the bench sets the count, the answer delay and a mute switch.
`timescale 1ns/100ps
module tld_front_end_model (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic burst_start_i,
  input wire logic [9:0] count_value_i,
  input wire logic [4:0] delay_i,
  input wire logic mute_i,
  output logic [9:0] count_o,
  output logic count_valid_o
);
  logic [4:0] wait_cnt; // Cycles left before answering
  logic busy; // Burst in flight
  // Answer after the delay; count line toggles outside the strobe
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      busy <= 1'b0;
      wait_cnt <= 5'h00;
      count_valid_o <= 1'b0;
      count_o <= 10'h000;
    end else begin
      count_valid_o <= 1'b0;
      count_o <= ~count_o;
      if (burst_start_i && !mute_i) begin
        busy <= 1'b1;
        wait_cnt <= delay_i;
      end else if (busy && wait_cnt > 5'h01) begin
        wait_cnt <= wait_cnt - 5'h01;
      end else if (busy) begin
        busy <= 1'b0;
        count_valid_o <= 1'b1;
        count_o <= count_value_i;
      end
    end
  end
endmodule : tld_front_end_model

// file: tb/tld_level_detect_properties.sv
// Checker for the two-tier level decision top: pin float, burst pulse, bypass trips.
// Assumes the partner answers only inside a burst and the polarity strap is high in bypass tests.
`timescale 1ns/100ps
module tld_level_detect_properties #(
  parameter int HEALTH_CYC = 5, // Health float length
  parameter int PERIOD_CYC = 40, // Burst spacing
  parameter int TIMEOUT_CYC = 20 // Burst watchdog
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic filter_enable_strap_i,
  input wire logic output_polarity_strap_i,
  input wire logic burst_start_o,
  input wire logic [tld_pkg::COUNT_W-1:0] count_i,
  input wire logic count_valid_i,
  input wire logic lower_tier_level_output_o,
  input wire logic lower_tier_level_output_oe_b_o,
  input wire logic upper_tier_level_output_o,
  input wire logic upper_tier_level_output_oe_b_o,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic irq_o
);
  import tld_pkg::*;
  // Short aliases keep the properties readable
  logic lo;
  logic up;
  logic lo_z;
  logic trip_ok;
  assign lo = lower_tier_level_output_o;
  assign up = upper_tier_level_output_o;
  assign lo_z = lower_tier_level_output_oe_b_o;
  // Bypass trips only judged with active-high pins
  assign trip_ok = count_valid_i && !filter_enable_strap_i && output_polarity_strap_i;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_health_float;
    $rose(lo_z) |-> lo_z [*5] ##1 (!lo_z && burst_start_o);
  endproperty
  a_health_float: assert property (p_health_float)
    else $error("health float length or burst start wrong");
  property p_float_both;
    lo_z == upper_tier_level_output_oe_b_o;
  endproperty
  a_float_both: assert property (p_float_both)
    else $error("tiers float apart");
  property p_start_pulse;
    burst_start_o |=> !burst_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("burst start longer than one cycle");
  property p_lower_on;
    trip_ok && count_i <= 10'h0FA |-> ##3 lo;
  endproperty
  a_lower_on: assert property (p_lower_on)
    else $error("lower tier missed a trip");
  property p_upper_on;
    trip_ok && count_i <= 10'h096 |-> ##3 up;
  endproperty
  a_upper_on: assert property (p_upper_on)
    else $error("upper tier missed a trip");
  property p_lower_off;
    trip_ok && count_i > 10'h0FD |-> ##3 !lo;
  endproperty
  a_lower_off: assert property (p_lower_off)
    else $error("lower tier held past hysteresis");
  // With the polarity strap steady, lower pin moves only three cycles after a count, never by timeout
  property p_lower_quiet;
    $changed(lo) && $past(rst_b_i, 2) && $stable(output_polarity_strap_i)
      && $past(output_polarity_strap_i) == $past(output_polarity_strap_i, 2)
      |-> $past(count_valid_i, 3);
  endproperty
  a_lower_quiet: assert property (p_lower_quiet)
    else $error("lower pin changed without a count");
  property p_polarity;
    $changed(output_polarity_strap_i) && $past(rst_b_i) |=> $changed(lo);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("polarity change not applied");
  c_burst: cover property (burst_start_o);
  c_upper_trip: cover property (count_valid_i && count_i <= 10'h096);
  c_irq: cover property ($rose(irq_o));
endmodule : tld_level_detect_properties

bind tld_level_detect tld_level_detect_properties #(
  .HEALTH_CYC(HEALTH_CYC), .PERIOD_CYC(PERIOD_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)
) tld_level_detect_properties_inst (
  .sys_clk_i, .rst_b_i, .filter_enable_strap_i, .output_polarity_strap_i, .burst_start_o,
  .count_i, .count_valid_i, .lower_tier_level_output_o, .lower_tier_level_output_oe_b_o,
  .upper_tier_level_output_o, .upper_tier_level_output_oe_b_o, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o
);

// file: tb/tld_level_detect_tb_top.sv
// Testbench: register checks, bypass trips, slosh filter, timeout and interrupt.
// Assumes shortened health, period and timeout counts.
`timescale 1ns/100ps
module tld_level_detect_tb_top;
  import tld_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic filter_enable_strap_i = 1'b0;
  logic output_polarity_strap_i = 1'b1;
  logic burst_start_o;
  logic [COUNT_W-1:0] count_i;
  logic count_valid_i;
  logic lower_tier_level_output_o;
  logic lower_tier_level_output_oe_b_o;
  logic upper_tier_level_output_o;
  logic upper_tier_level_output_oe_b_o;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic irq_o;
  logic [9:0] fe_count = 10'h000;
  logic [4:0] fe_delay = 5'h01;
  logic fe_mute = 1'b0;
  int miscompares = 0;
  int checks = 0;
  int j;
  // Bypass table: count per burst, expected {upper, lower} pins
  logic [9:0] cnt_tab [7] = '{10'h12C, 10'h0FA, 10'h0FD, 10'h0FE, 10'h096, 10'h099, 10'h09A};
  logic [1:0] exp_tab [7] = '{2'b00, 2'b01, 2'b01, 2'b00, 2'b11, 2'b11, 2'b01};
  always #5 sys_clk_i = ~sys_clk_i;
  tld_level_detect #(.HEALTH_CYC(5), .PERIOD_CYC(40), .TIMEOUT_CYC(20)) tld_level_detect_inst (
    .sys_clk_i, .rst_b_i, .filter_enable_strap_i, .output_polarity_strap_i, .burst_start_o,
    .count_i, .count_valid_i, .lower_tier_level_output_o, .lower_tier_level_output_oe_b_o,
    .upper_tier_level_output_o, .upper_tier_level_output_oe_b_o, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);
  tld_front_end_model tld_front_end_model_inst (.sys_clk_i, .rst_b_i,
    .burst_start_i(burst_start_o), .count_value_i(fe_count), .delay_i(fe_delay),
    .mute_i(fe_mute), .count_o(count_i), .count_valid_o(count_valid_i));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic conclude();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask : rchk
  // Run n bursts with one count; bounded wait for each request
  task automatic bursts(input int n, input logic [9:0] c);
    int i;
    int k;
    fe_count <= c;
    for (k = 0; k < n; k++) begin
      for (i = 0; i < 200 && burst_start_o !== 1'b1; i++) begin
        @(posedge sys_clk_i);
        #1;
      end
      if (i == 200) begin
        miscompares++;
        conclude();
      end
      repeat (25) @(posedge sys_clk_i);
      #1;
    end
  endtask : bursts
  task automatic pins(input logic [1:0] exp);
    chk({30'h0, upper_tier_level_output_o, lower_tier_level_output_o}, {30'h0, exp});
  endtask : pins
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rchk(REG_STATUS, 32'h0);
    rchk(REG_STATE, 32'h20);
    rchk(8'h0C, 32'h0);
    wr_reg(REG_MASK, 32'hFFFFFFFF);
    rchk(REG_MASK, 32'hF);
    wr_reg(REG_MASK, 32'h0);
    wr_reg(REG_STATE, 32'hFFFFFFFF);
    rchk(REG_STATE, 32'h20);
    $display("test registers done");
    for (j = 0; j < 7; j++) begin
      bursts(1, cnt_tab[j]);
      pins(exp_tab[j]);
      chk({31'h0, lower_tier_level_output_oe_b_o}, 32'h0);
    end
    @(posedge sys_clk_i);
    output_polarity_strap_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    pins(2'b10);
    @(posedge sys_clk_i);
    output_polarity_strap_i <= 1'b1;
    $display("test bypass done");
    // Filter switched on live; slow partner answers
    @(posedge sys_clk_i);
    filter_enable_strap_i <= 1'b1;
    fe_delay <= 5'h0C;
    rchk(REG_STATE, 32'h00009635);
    bursts(149, 10'h064);
    rchk(REG_STATE, 32'h00959637);
    pins(2'b01);
    bursts(1, 10'h064);
    pins(2'b11);
    bursts(1, 10'h12C);
    rchk(REG_STATE, 32'h0095953C);
    bursts(148, 10'h12C);
    pins(2'b11);
    bursts(1, 10'h12C);
    pins(2'b00);
    bursts(1, 10'h12C);
    rchk(REG_STATE, 32'h00000030);
    $display("test filter done");
    @(posedge sys_clk_i);
    filter_enable_strap_i <= 1'b0;
    fe_delay <= 5'h01;
    wr_reg(REG_STATUS, 32'hF);
    fe_mute <= 1'b1;
    bursts(1, 10'h12C);
    rchk(REG_STATUS, 32'h8);
    fe_mute <= 1'b0;
    wr_reg(REG_MASK, 32'h4);
    bursts(1, 10'h12C);
    chk({31'h0, irq_o}, 32'h1);
    wr_reg(REG_MASK, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr_reg(REG_MASK, 32'h4);
    chk({31'h0, irq_o}, 32'h1);
    wr_reg(REG_STATUS, 32'h4);
    chk({31'h0, irq_o}, 32'h0);
    $display("test timeout and interrupt done");
    conclude();
  end
endmodule : tld_level_detect_tb_top
